// file: rtl/scsel_pkg.sv
// constants and types of the system clock selector
package scsel_pkg;
   // ======================================================
   // register map
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;
   // ======================================================
   // control field positions and reset value
   localparam int          SRC_BIT      = 0;
   localparam int          STOP_BIT     = 1;
   localparam int          DIV_LO_BIT   = 2;
   localparam int          DIV_HI_BIT   = 3;
   localparam logic [3:0]  CTRL_RESET   = 4'hC;
   // ======================================================
   // instruction clock ratio
   localparam logic [1:0]  INSTR_LAST   = 2'h2;

   typedef struct packed {
      logic [1:0] div;
      logic       stop;
      logic       src;
   } scsel_cfg_type;

   typedef enum logic [1:0] {
      MAIN_RING = 2'b00,
      MAIN_CER  = 2'b01,
      MAIN_RC   = 2'b10
   } scsel_main_type;
endpackage

// file: rtl/scsel_divider.sv
// source edge divider by 1, 2, 4 or 8
`timescale 1ns/10ps
module scsel_divider (
   // clock, reset and enable
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // source and ratio
   input  wire logic       edge_in,
   input  wire logic [1:0] ratio,
   // divided output
   output logic            wrap
);
   logic [2:0] cnt_ff;
   logic [2:0] limit;

   function automatic logic [2:0] last_count(input logic [1:0] r);
      case (r)
         2'b00:   last_count = 3'h0;
         2'b01:   last_count = 3'h1;
         2'b10:   last_count = 3'h3;
         default: last_count = 3'h7;
      endcase
   endfunction

   assign limit = last_count(ratio);
   assign wrap  = edge_in && (cnt_ff >= limit);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 3'h0;
      end else if (ce && edge_in) begin
         cnt_ff <= wrap ? 3'h0 : cnt_ff + 3'h1;
      end
   end

   a_div_count: assert property (@(posedge clk) disable iff (rst)
      ce && edge_in && cnt_ff < limit |=> cnt_ff == $past(cnt_ff) + 3'h1)
      else $error("divider count did not advance");
endmodule

// file: rtl/scsel_top.sv
// system clock source selection, division and instruction clock
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/10ps
module scsel_top #(
   parameter int MC_W = 16
) (
   // clock, reset, enable
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // oscillator pins and instructions
   input  wire logic        MAIN_OSC_INPUT,
   input  wire logic        RING_OSC_INPUT,
   input  wire logic        SUB_OSC_INPUT,
   input  wire logic        CERAMIC_SELECT_INSTR,
   input  wire logic        RC_SELECT_INSTR,
   // clocks, cycle count and main source status out
   output logic             SYSTEM_CLOCK_SIGNAL,
   output logic             INSTRUCTION_CLOCK,
   output logic [MC_W-1:0]  MACHINE_CYCLES,
   output logic             MAIN_RUN,
   output logic [1:0]       MAIN_MODE
);
   // narrower counts wrap too fast to time anything
   if (MC_W < 4 || MC_W > 32) begin : g_mc_w_bad
      $error("MC_W out of range");
   end

   // ======================================================
   // pin synchronisers
   logic [2:0] s1_ff;
   logic [2:0] s2_ff;
   logic [2:0] s3_ff;
   logic [2:0] rise;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         s1_ff <= 3'h0;
         s2_ff <= 3'h0;
         s3_ff <= 3'h0;
      end else if (CE) begin
         s1_ff <= {SUB_OSC_INPUT, RING_OSC_INPUT, MAIN_OSC_INPUT};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end
   assign rise = s2_ff & ~s3_ff;

   // ======================================================
   // registers and main origin
   scsel_pkg::scsel_cfg_type   ctrl_ff;
   scsel_pkg::scsel_cfg_type   act_ff;
   scsel_pkg::scsel_main_type  mode_ff;
   logic                       main_run;
   logic                       stalled;
   logic                       src_edge;
   logic                       main_edge;
   logic                       wrap;
   logic                       ack_ff;
   logic                       wr_en;
   logic                       hit_ctrl;
   logic                       hit_stat;

   assign hit_ctrl = PADDR == scsel_pkg::CTRL_OFFSET;
   assign hit_stat = PADDR == scsel_pkg::STATUS_OFFSET;
   assign PREADY   = ack_ff && CE;
   assign wr_en    = PSEL && PENABLE && PWRITE && PREADY;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ctrl_ff <= scsel_pkg::CTRL_RESET;
      end else if (CE && wr_en && hit_ctrl) begin
         ctrl_ff <= PWDATA[3:0];
      end
   end

   // sticky until reset: no instruction returns to on-chip
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         mode_ff <= scsel_pkg::MAIN_RING;
      end else if (CE && CERAMIC_SELECT_INSTR) begin
         mode_ff <= scsel_pkg::MAIN_CER;
      end else if (CE && RC_SELECT_INSTR) begin
         mode_ff <= scsel_pkg::MAIN_RC;
      end
   end

   // ======================================================
   // apb answer, one wait-free access phase
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         ack_ff  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         ack_ff  <= PSEL && !ack_ff;
         if (PSEL && !ack_ff) begin
            PSLVERR <= !(hit_ctrl || hit_stat);
            if (hit_ctrl) begin
               PRDATA <= {28'h0000000, ctrl_ff};
            end else if (hit_stat) begin
               PRDATA <= {25'h0000000, main_run, mode_ff, act_ff};
            end else begin
               PRDATA <= 32'h0000_0000;
            end
         end
      end
   end

   // ======================================================
   // source multiplexer
   assign main_run = !(ctrl_ff.src && ctrl_ff.stop);
   // a stopped main source never wraps, so it hands over at once
   assign stalled  = !act_ff.src && (act_ff.stop || !main_run);

   always_comb begin
      case (mode_ff)
         scsel_pkg::MAIN_CER: main_edge = rise[0];
         scsel_pkg::MAIN_RC:  main_edge = rise[0];
         default:             main_edge = rise[1];
      endcase
   end

   always_comb begin
      if (act_ff.src) begin
         src_edge = rise[2];
      end else if (!act_ff.stop) begin
         src_edge = main_edge && main_run;
      end else begin
         src_edge = 1'b0;
      end
   end

   scsel_divider u_div (
      .clk     (SYS_CLK),
      .rst     (RST),
      .ce      (CE),
      .edge_in (src_edge),
      .ratio   (act_ff.div),
      .wrap    (wrap)
   );

   // new setting waits for the old period to finish, or applies at once while the main source is stalled; no runt pulse
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         act_ff <= scsel_pkg::CTRL_RESET;
      end else if (CE && (wrap || stalled)) begin
         act_ff <= ctrl_ff;
      end
   end

   // ======================================================
   // system and instruction clocks
   logic [1:0] phase_ff;
   logic       inst_tick;

   assign inst_tick = wrap && phase_ff == scsel_pkg::INSTR_LAST;

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         SYSTEM_CLOCK_SIGNAL <= 1'b0;
         INSTRUCTION_CLOCK   <= 1'b0;
         phase_ff            <= 2'h0;
      end else if (CE) begin
         SYSTEM_CLOCK_SIGNAL <= wrap;
         INSTRUCTION_CLOCK   <= inst_tick;
         if (wrap) begin
            phase_ff <= inst_tick ? 2'h0 : phase_ff + 2'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         MACHINE_CYCLES <= '0;
      end else if (CE && inst_tick) begin
         MACHINE_CYCLES <= MACHINE_CYCLES + 1'b1;
      end
   end

   assign MAIN_RUN  = main_run;
   assign MAIN_MODE = mode_ff;

   // ======================================================
   // checks
   a_tick_on_wrap: assert property (@(posedge SYS_CLK) disable iff (RST)
      CE && wrap |=> SYSTEM_CLOCK_SIGNAL)
      else $error("system clock pulse missing after wrap");
   a_sub_source: assert property (@(posedge SYS_CLK) disable iff (RST)
      act_ff.src |-> src_edge == rise[2])
      else $error("sub clock not used as source");
   a_main_source: assert property (@(posedge SYS_CLK) disable iff (RST)
      !act_ff.src && !stalled && mode_ff == scsel_pkg::MAIN_RING
      |-> src_edge == rise[1])
      else $error("on-chip clock not used as source");
   a_instr_third: assert property (@(posedge SYS_CLK) disable iff (RST)
      CE && $past(CE) && INSTRUCTION_CLOCK
      |-> $past(phase_ff) == 2'h2 && $past(wrap))
      else $error("instruction clock not on third tick");
   a_machine_step: assert property (@(posedge SYS_CLK) disable iff (RST)
      CE && inst_tick |=> MACHINE_CYCLES == $past(MACHINE_CYCLES) + 1'b1)
      else $error("machine cycle not counted");
   a_reset_config: assert property (@(posedge SYS_CLK)
      $past(RST) && !RST |-> act_ff == 4'hC && mode_ff == 2'b00)
      else $error("reset configuration wrong");
   a_main_halt: assert property (@(posedge SYS_CLK) disable iff (RST)
      CE && ctrl_ff.src && ctrl_ff.stop |-> !MAIN_RUN ##1 act_ff.src)
      else $error("main clock not halted");
   a_select_instr: assert property (@(posedge SYS_CLK) disable iff (RST)
      CE && CERAMIC_SELECT_INSTR |=> mode_ff == scsel_pkg::MAIN_CER)
      else $error("ceramic select not taken");
   a_clean_switch: assert property (@(posedge SYS_CLK) disable iff (RST)
      CE && !wrap && !stalled |=> $stable(act_ff))
      else $error("setting changed mid period");
endmodule

// file: tb/tb_top.sv
// self-checking bench of the system clock selector
`timescale 1ns/10ps
module tb_top;
   // ===================================================
   // design signals
   logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, main_osc = 0, ring = 0, sub = 0;
   logic        cer = 0, rcs = 0, ce = 1, system_clock_signal, instruction_clock, run;
   logic [15:0] mc;
   logic [1:0]  mode;
   logic [3:0]  c_m = 0, c_r = 0, c_s = 0;
   int          n_errors = 0, cmp_count = 0;

   always #2.5 sys_clk = ~sys_clk;

   // distinct periods (main 10, ring 8, sub 12) expose a wrong source
   always @(posedge sys_clk) begin
      c_m <= (c_m == 4'h4) ? 4'h0 : c_m + 4'h1;
      c_r <= (c_r == 4'h3) ? 4'h0 : c_r + 4'h1;
      c_s <= (c_s == 4'h5) ? 4'h0 : c_s + 4'h1;
      if (c_m == 4'h4) main_osc <= ~main_osc;
      if (c_r == 4'h3) ring <= ~ring;
      if (c_s == 4'h5) sub <= ~sub;
   end

   scsel_top dut_u (.SYS_CLK(sys_clk), .RST(rst), .CE(ce), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MAIN_OSC_INPUT(main_osc), .RING_OSC_INPUT(ring),
      .SUB_OSC_INPUT(sub), .CERAMIC_SELECT_INSTR(cer),
      .RC_SELECT_INSTR(rcs), .SYSTEM_CLOCK_SIGNAL(system_clock_signal),
      .INSTRUCTION_CLOCK(instruction_clock), .MACHINE_CYCLES(mc), .MAIN_RUN(run),
      .MAIN_MODE(mode));

   // ===================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      #1;
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, x, r);
      chk("slverr", {31'h0, xe}, {31'h0, e});
   endtask

   // cycles between pulses; the first gaps absorb a pending switch
   task automatic gap(input bit ins, input int n, output int g);
      for (int k = 0; k < n; k++) begin
         g = 0;
         do begin
            @(posedge sys_clk);
            #1;
            g++;
         end while ((ins ? instruction_clock : system_clock_signal) !== 1'b1 && g < 3000);
      end
   endtask

   task automatic do_reset;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
   endtask

   // ===================================================
   // scenarios
   task automatic s_reset;
      int g;
      rdc("ctrl", scsel_pkg::CTRL_OFFSET, 32'hC, 1'b0);
      rdc("status", scsel_pkg::STATUS_OFFSET, 32'h4C, 1'b0);
      chk("mode", 32'h0, {30'h0, mode});
      gap(1'b0, 3, g);
      chk("reset gap", 64, g);
      rdc("unmapped", 12'h008, 32'h0, 1'b1);
      wr(12'h008, 32'h0);
      rdc("ctrl kept", scsel_pkg::CTRL_OFFSET, 32'hC, 1'b0);
   endtask

   task automatic s_div;
      int          g;
      logic [15:0] m0;
      for (int d = 0; d < 4; d++) begin
         wr(scsel_pkg::CTRL_OFFSET, d << 2);
         gap(1'b0, 4, g);
         chk("sys gap", 8 << d, g);
         gap(1'b1, 2, g);
         m0 = mc;
         gap(1'b1, 1, g);
         chk("instr gap", 24 << d, g);
         chk("cycles", {16'h0, m0 + 16'h1}, {16'h0, mc});
      end
   endtask

   task automatic s_sub;
      int g;
      wr(scsel_pkg::CTRL_OFFSET, 32'h7);
      gap(1'b0, 4, g);
      chk("sub stop gap", 24, g);
      chk("main run", 32'h0, {31'h0, run});
      rdc("status", scsel_pkg::STATUS_OFFSET, 32'h07, 1'b0);
      wr(scsel_pkg::CTRL_OFFSET, 32'h5);
      gap(1'b0, 4, g);
      chk("sub gap", 24, g);
   endtask

   // low enable must hold the machine cycle count and the system clock output
   task automatic s_freeze;
      logic [15:0] m0;
      logic        s0;
      @(posedge sys_clk);
      ce <= 1'b0;
      #1;
      m0 = mc;
      s0 = system_clock_signal;
      repeat (40) @(posedge sys_clk);
      #1;
      chk("frozen cycles", {16'h0, m0}, {16'h0, mc});
      chk("frozen clock", {31'h0, s0}, {31'h0, system_clock_signal});
      @(posedge sys_clk);
      ce <= 1'b1;
   endtask

   // rc alone gives mode 2; ceramic beside rc wins with mode 1
   task automatic s_mode;
      int g;
      for (int k = 0; k < 2; k++) begin
         do_reset;
         @(posedge sys_clk);
         cer <= k[0];
         rcs <= 1'b1;
         @(posedge sys_clk);
         cer <= 1'b0;
         rcs <= 1'b0;
         repeat (2) @(posedge sys_clk);
         #1;
         chk("mode", k ? 32'h1 : 32'h2, {30'h0, mode});
         wr(scsel_pkg::CTRL_OFFSET, 32'h0);
         gap(1'b0, 4, g);
         chk("main gap", 10, g);
      end
   endtask

   task automatic results;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ===================================================
   // sequence and watchdog
   initial begin
      do_reset;
      s_reset;
      s_div;
      s_sub;
      s_freeze;
      s_mode;
      results;
   end

   // run needs about 2.5k cycles; 60k leaves wide margin
   initial begin
      #300000;
      n_errors++;
      results;
   end
endmodule
